// ### logic/plcr_frame.sv
// plcr_frame: decodes a latched command into line fields when it goes out
module plcr_frame (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 send_i,
	input  wire logic [6:0]           code_i,
	input  wire logic [7:0]           arg_i,
	output plcr_pkg::plcr_kind_e      kind_o,
	output logic      [3:0]           gpio_res_en_o,
	output logic      [3:0]           gpio_level_o,
	output logic      [8:0]           dout_len_o,
	output logic      [1:0]           uart_chan_o,
	output logic                      uart_rx_sw_o,
	output logic                      uart_tx_sw_o,
	output plcr_pkg::plcr_sys_e       sys_req_o
);

	plcr_pkg::plcr_kind_e kind;
	assign kind = plcr_pkg::code_kind(code_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			kind_o        <= plcr_pkg::KIND_NONE;
			gpio_res_en_o <= 4'h0;
			gpio_level_o  <= 4'h0;
			dout_len_o    <= 9'h000;
			uart_chan_o   <= plcr_pkg::CHAN_NONE;
			uart_rx_sw_o  <= 1'b0;
			uart_tx_sw_o  <= 1'b0;
			sys_req_o     <= plcr_pkg::SYS_NONE;
		end else if (send_i) begin
			kind_o        <= kind;
			gpio_res_en_o <= (kind == plcr_pkg::KIND_GPIO) ? arg_i[7:4] : 4'h0;
			gpio_level_o  <= (kind == plcr_pkg::KIND_GPIO) ? arg_i[3:0] : 4'h0;
			dout_len_o    <= (kind == plcr_pkg::KIND_DOUT) ? ({1'b0, arg_i} + 9'h001) : 9'h000;
			uart_chan_o   <= plcr_pkg::CHAN_NONE;
			uart_rx_sw_o  <= 1'b0;
			uart_tx_sw_o  <= 1'b0;
			sys_req_o     <= plcr_pkg::SYS_NONE;
			if (kind == plcr_pkg::KIND_UART) begin
				case (arg_i)
					plcr_pkg::UART_MANUAL: begin
						uart_chan_o <= plcr_pkg::CHAN_NONE;
					end
					plcr_pkg::UART_CH1_RX: begin
						uart_chan_o  <= plcr_pkg::CHAN_ONE;
						uart_rx_sw_o <= 1'b1;
					end
					plcr_pkg::UART_CH1_TX: begin
						uart_chan_o  <= plcr_pkg::CHAN_ONE;
						uart_tx_sw_o <= 1'b1;
					end
					plcr_pkg::UART_CH1_LOOP: begin
						uart_chan_o  <= plcr_pkg::CHAN_ONE;
						uart_rx_sw_o <= 1'b1;
						uart_tx_sw_o <= 1'b1;
					end
					plcr_pkg::UART_CH2_RX: begin
						uart_chan_o  <= plcr_pkg::CHAN_TWO;
						uart_rx_sw_o <= 1'b1;
					end
					plcr_pkg::UART_CH2_TX: begin
						uart_chan_o  <= plcr_pkg::CHAN_TWO;
						uart_tx_sw_o <= 1'b1;
					end
					plcr_pkg::UART_CH2_LOOPA, plcr_pkg::UART_CH2_LOOPB: begin
						uart_chan_o  <= plcr_pkg::CHAN_TWO;
						uart_rx_sw_o <= 1'b1;
						uart_tx_sw_o <= 1'b1;
					end
					default: begin
						uart_chan_o <= plcr_pkg::CHAN_NONE;
					end
				endcase
			end
			if (kind == plcr_pkg::KIND_SYS) begin
				case (arg_i)
					plcr_pkg::SYS_ARG_SOFT:  sys_req_o <= plcr_pkg::SYS_SOFT;
					plcr_pkg::SYS_ARG_GAUGE: sys_req_o <= plcr_pkg::SYS_GAUGE;
					plcr_pkg::SYS_ARG_FIFO:  sys_req_o <= plcr_pkg::SYS_FIFO;
					plcr_pkg::SYS_ARG_FREE:  sys_req_o <= plcr_pkg::SYS_FREE;
					default:                 sys_req_o <= plcr_pkg::SYS_NONE;
				endcase
			end
		end
	end

endmodule : plcr_frame

// ### logic/plcr_pkg.sv
// plcr_pkg: shared constants, types and decoding for the command issue register slice
package plcr_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_ARG      = 8'h37;
	localparam logic [7:0] ADDR_CMD      = 8'h38;
	localparam logic [7:0] ADDR_RX_COUNT = 8'h39;
	localparam logic [7:0] ADDR_SOC      = 8'h3A;
	localparam logic [7:0] ADDR_GAUGE    = 8'h3B;

	localparam logic [7:0] RST_ARG       = 8'h00;
	localparam logic [6:0] RST_CODE      = 7'h00;
	localparam logic [6:0] RST_RX_COUNT  = 7'h00;
	localparam logic [7:0] RST_SOC       = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	localparam int TRIG_BIT  = 7;
	localparam int VALID_BIT = 7;

	// ************************************************************
	// command codes and arguments
	// ************************************************************
	localparam logic [6:0] CODE_SYS  = 7'h00;
	localparam logic [6:0] CODE_GPIO = 7'h03;
	localparam logic [6:0] CODE_DOUT = 7'h05;
	localparam logic [6:0] CODE_UART = 7'h06;

	localparam logic [7:0] UART_MANUAL    = 8'h00;
	localparam logic [7:0] UART_CH1_RX    = 8'h01;
	localparam logic [7:0] UART_CH1_TX    = 8'h02;
	localparam logic [7:0] UART_CH1_LOOP  = 8'h03;
	localparam logic [7:0] UART_CH2_RX    = 8'h04;
	localparam logic [7:0] UART_CH2_TX    = 8'h07;
	localparam logic [7:0] UART_CH2_LOOPA = 8'h08;
	localparam logic [7:0] UART_CH2_LOOPB = 8'h0C;

	localparam logic [7:0] SYS_ARG_SOFT  = 8'h01;
	localparam logic [7:0] SYS_ARG_GAUGE = 8'h03;
	localparam logic [7:0] SYS_ARG_FIFO  = 8'h04;
	localparam logic [7:0] SYS_ARG_FREE  = 8'h05;

	localparam logic [1:0] CHAN_NONE = 2'h0;
	localparam logic [1:0] CHAN_ONE  = 2'h1;
	localparam logic [1:0] CHAN_TWO  = 2'h2;

	// arbitrary neutral bus address, not tied to any part
	localparam logic [6:0] BUS_ADDR = 7'h2A;

	typedef enum logic [2:0] {KIND_NONE, KIND_SYS, KIND_GPIO, KIND_DOUT, KIND_UART} plcr_kind_e;
	typedef enum logic [2:0] {SYS_NONE, SYS_SOFT, SYS_GAUGE, SYS_FIFO, SYS_FREE} plcr_sys_e;

	function automatic plcr_kind_e code_kind(input logic [6:0] code);
		case (code)
			CODE_SYS:  code_kind = KIND_SYS;
			CODE_GPIO: code_kind = KIND_GPIO;
			CODE_DOUT: code_kind = KIND_DOUT;
			CODE_UART: code_kind = KIND_UART;
			default:   code_kind = KIND_NONE;
		endcase
	endfunction : code_kind

endpackage : plcr_pkg

// ### logic/plcr_regs.sv
// plcr_regs: two-wire register slice that issues commands over the power line
// Behaviour
// - writing trigger bit starts selected command
// - trigger held until sent at poll
// - trigger reads one while command pending
// - code 00 sys, 03 gpio, 05 dout, 06 uart
// - gpio argument: enables high, levels low
// - data-out length is argument plus one
// - uart argument zero: manual, switches off
// - channel one: 1 rx, 2 tx, 3 loop
// - channel two: 4 rx, 7 tx, 8/C loop
// - sys argument: 1,3,4,5 reset/gauge/fifo/free
// - received count stored as reported, no offset
// - count updates with new-data pulse
// - partner charge byte readable, not valid-gated
// - charge byte is one percent per bit
// - gauge status bit seven shows validity
// - nack data-out while receive buffer full
// - nack uart request when refuse set
module plcr_regs (
	input  wire logic                 CLOCK_I,
	input  wire logic                 ARST_N_I,
	input  wire logic                 I2C_SCL_I,
	input  wire logic                 I2C_SDA_I,
	output logic                      I2C_SDA_O,
	output logic                      I2C_SDA_OE_O,
	input  wire logic                 LINK_POLL_I,
	output logic                      LINK_TX_STB_O,
	output logic      [6:0]           LINK_TX_CODE_O,
	output logic      [7:0]           LINK_TX_ARG_O,
	output plcr_pkg::plcr_kind_e      LINK_TX_KIND_O,
	output logic      [3:0]           LINK_GPIO_RES_EN_O,
	output logic      [3:0]           LINK_GPIO_LEVEL_O,
	output logic      [8:0]           LINK_DOUT_LEN_O,
	output logic      [1:0]           LINK_UART_CHAN_O,
	output logic                      LINK_UART_RX_SW_O,
	output logic                      LINK_UART_TX_SW_O,
	output plcr_pkg::plcr_sys_e       LINK_SYS_REQ_O,
	output logic                      CMD_PENDING_O,
	input  wire logic                 LINK_REQ_STB_I,
	input  wire logic [6:0]           LINK_REQ_CODE_I,
	input  wire logic                 RX_BUFFER_FULL_I,
	input  wire logic                 UART_REFUSE_I,
	output logic                      LINK_REQ_ACK_O,
	output logic                      LINK_REQ_NACK_O,
	input  wire logic                 LINK_RX_DONE_I,
	input  wire logic [6:0]           LINK_RX_COUNT_I,
	output logic                      RX_NEW_DATA_O,
	input  wire logic                 LINK_SOC_STB_I,
	input  wire logic [7:0]           LINK_SOC_I,
	input  wire logic                 LINK_GAUGE_OK_I
);

	// ************************************************************
	// reset release and pin synchronisation
	// ************************************************************
	logic       rst_s1_r;
	logic       rst_n;
	logic [1:0] pins;
	logic       scl;
	logic       sda;
	logic       scl_prev_r;
	logic       sda_prev_r;

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	plcr_sync #(
		.WIDTH (2),
		.INIT  (2'h3)
	) u_sync (
		.clk_i   (CLOCK_I),
		.rst_n_i (rst_n),
		.pin_i   ({I2C_SCL_I, I2C_SDA_I}),
		.level_o (pins)
	);

	assign scl = pins[1];
	assign sda = pins[0];

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_prev_r <= scl;
			sda_prev_r <= sda;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise  = scl & ~scl_prev_r;
	assign scl_fall  = ~scl & scl_prev_r;
	assign bus_start = scl & scl_prev_r & sda_prev_r & ~sda;
	assign bus_stop  = scl & scl_prev_r & ~sda_prev_r & sda;

	// ************************************************************
	// two-wire slave engine
	// ************************************************************
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD, ST_MACK} plcr_bus_e;

	plcr_bus_e  bus_st_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic       ack_r;
	logic       rd_next_r;
	logic       mnack_r;
	logic       wr_stb_r;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic [7:0] rd_data;

	// the open-drain line only ever pulls low
	assign I2C_SDA_O = 1'b0;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			bus_st_r     <= ST_IDLE;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			tx_r         <= 8'h00;
			ptr_r        <= 8'h00;
			ack_r        <= 1'b0;
			rd_next_r    <= 1'b0;
			mnack_r      <= 1'b0;
			I2C_SDA_OE_O <= 1'b0;
			wr_stb_r     <= 1'b0;
			wr_addr_r    <= 8'h00;
			wr_data_r    <= 8'h00;
		end else begin
			wr_stb_r <= 1'b0;
			if (bus_stop) begin
				bus_st_r     <= ST_IDLE;
				ack_r        <= 1'b0;
				I2C_SDA_OE_O <= 1'b0;
			end else if (bus_start) begin
				bus_st_r     <= ST_ADDR;
				bit_cnt_r    <= 4'h0;
				ack_r        <= 1'b0;
				I2C_SDA_OE_O <= 1'b0;
			end else if (scl_rise && !ack_r) begin
				if (bus_st_r == ST_MACK) begin
					mnack_r <= sda;
				end else if (bus_st_r != ST_IDLE) begin
					shift_r   <= {shift_r[6:0], sda};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
			end else if (scl_fall) begin
				if (ack_r) begin
					ack_r     <= 1'b0;
					bit_cnt_r <= 4'h0;
					if (rd_next_r) begin
						bus_st_r     <= ST_RD;
						tx_r         <= rd_data;
						ptr_r        <= ptr_r + 8'h01;
						I2C_SDA_OE_O <= ~rd_data[7];
					end else begin
						I2C_SDA_OE_O <= 1'b0;
					end
				end else begin
					case (bus_st_r)
						ST_ADDR: begin
							if (bit_cnt_r == 4'h8) begin
								if (shift_r[7:1] == plcr_pkg::BUS_ADDR) begin
									ack_r        <= 1'b1;
									I2C_SDA_OE_O <= 1'b1;
									rd_next_r    <= shift_r[0];
									bus_st_r     <= shift_r[0] ? ST_ADDR : ST_PTR;
								end else begin
									// another device on the bus: wait for stop
									bus_st_r <= ST_IDLE;
								end
							end
						end
						ST_PTR: begin
							if (bit_cnt_r == 4'h8) begin
								ptr_r        <= shift_r;
								ack_r        <= 1'b1;
								I2C_SDA_OE_O <= 1'b1;
								bus_st_r     <= ST_WR;
							end
						end
						ST_WR: begin
							if (bit_cnt_r == 4'h8) begin
								wr_stb_r     <= 1'b1;
								wr_addr_r    <= ptr_r;
								wr_data_r    <= shift_r;
								ptr_r        <= ptr_r + 8'h01;
								ack_r        <= 1'b1;
								I2C_SDA_OE_O <= 1'b1;
							end
						end
						ST_RD: begin
							if (bit_cnt_r == 4'h8) begin
								I2C_SDA_OE_O <= 1'b0;
								bus_st_r     <= ST_MACK;
							end else begin
								I2C_SDA_OE_O <= ~tx_r[3'h7 - bit_cnt_r[2:0]];
							end
						end
						ST_MACK: begin
							if (mnack_r) begin
								bus_st_r <= ST_IDLE;
							end else begin
								bus_st_r     <= ST_RD;
								bit_cnt_r    <= 4'h0;
								tx_r         <= rd_data;
								ptr_r        <= ptr_r + 8'h01;
								I2C_SDA_OE_O <= ~rd_data[7];
							end
						end
						default: begin
							bus_st_r <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ************************************************************
	// command argument and code
	// ************************************************************
	logic [7:0] arg_r;
	logic [6:0] code_r;
	logic       pending_r;
	logic [6:0] sent_code_r;
	logic [7:0] sent_arg_r;
	logic       trig_wr;
	logic       send;

	assign trig_wr = wr_stb_r && (wr_addr_r == plcr_pkg::ADDR_CMD) && wr_data_r[plcr_pkg::TRIG_BIT];
	// the pending command leaves on the partner's poll
	assign send    = pending_r && LINK_POLL_I;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			arg_r  <= plcr_pkg::RST_ARG;
			code_r <= plcr_pkg::RST_CODE;
		end else if (wr_stb_r) begin
			if (wr_addr_r == plcr_pkg::ADDR_ARG) begin
				arg_r <= wr_data_r;
			end
			if (wr_addr_r == plcr_pkg::ADDR_CMD) begin
				code_r <= wr_data_r[6:0];
			end
		end
	end

	// code and argument are frozen at trigger so later writes cannot alter it
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			pending_r   <= 1'b0;
			sent_code_r <= plcr_pkg::RST_CODE;
			sent_arg_r  <= plcr_pkg::RST_ARG;
		end else if (send) begin
			pending_r <= 1'b0;
		end else if (trig_wr && !pending_r) begin
			pending_r   <= 1'b1;
			sent_code_r <= wr_data_r[6:0];
			sent_arg_r  <= arg_r;
		end
		// a trigger write while pending falls through untouched
	end

	assign CMD_PENDING_O = pending_r;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			LINK_TX_STB_O  <= 1'b0;
			LINK_TX_CODE_O <= plcr_pkg::RST_CODE;
			LINK_TX_ARG_O  <= plcr_pkg::RST_ARG;
		end else begin
			LINK_TX_STB_O <= send;
			if (send) begin
				LINK_TX_CODE_O <= sent_code_r;
				LINK_TX_ARG_O  <= sent_arg_r;
			end
		end
	end

	plcr_frame u_frame (
		.clk_i         (CLOCK_I),
		.rst_n_i       (rst_n),
		.send_i        (send),
		.code_i        (sent_code_r),
		.arg_i         (sent_arg_r),
		.kind_o        (LINK_TX_KIND_O),
		.gpio_res_en_o (LINK_GPIO_RES_EN_O),
		.gpio_level_o  (LINK_GPIO_LEVEL_O),
		.dout_len_o    (LINK_DOUT_LEN_O),
		.uart_chan_o   (LINK_UART_CHAN_O),
		.uart_rx_sw_o  (LINK_UART_RX_SW_O),
		.uart_tx_sw_o  (LINK_UART_TX_SW_O),
		.sys_req_o     (LINK_SYS_REQ_O)
	);

	// ************************************************************
	// incoming requests from the partner
	// ************************************************************
	plcr_pkg::plcr_kind_e req_kind;
	logic                 req_refuse;

	assign req_kind   = plcr_pkg::code_kind(LINK_REQ_CODE_I);
	assign req_refuse = ((req_kind == plcr_pkg::KIND_DOUT) && RX_BUFFER_FULL_I)
		|| ((req_kind == plcr_pkg::KIND_UART) && UART_REFUSE_I);

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			LINK_REQ_ACK_O  <= 1'b0;
			LINK_REQ_NACK_O <= 1'b0;
		end else begin
			LINK_REQ_ACK_O  <= LINK_REQ_STB_I && !req_refuse;
			LINK_REQ_NACK_O <= LINK_REQ_STB_I && req_refuse;
		end
	end

	// ************************************************************
	// received count and partner gauge feedback
	// ************************************************************
	logic [6:0] rx_count_r;
	logic [7:0] soc_r;
	logic       gauge_ok_r;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			rx_count_r    <= plcr_pkg::RST_RX_COUNT;
			RX_NEW_DATA_O <= 1'b0;
		end else begin
			RX_NEW_DATA_O <= LINK_RX_DONE_I;
			if (LINK_RX_DONE_I) begin
				rx_count_r <= LINK_RX_COUNT_I;
			end
		end
	end

	// one percent per bit, stored raw with no scaling
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			soc_r      <= plcr_pkg::RST_SOC;
			gauge_ok_r <= 1'b0;
		end else if (LINK_SOC_STB_I) begin
			soc_r      <= LINK_SOC_I;
			gauge_ok_r <= LINK_GAUGE_OK_I;
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always_comb begin
		case (ptr_r)
			plcr_pkg::ADDR_ARG:      rd_data = arg_r;
			plcr_pkg::ADDR_CMD:      rd_data = {pending_r, code_r};
			plcr_pkg::ADDR_RX_COUNT: rd_data = {1'b0, rx_count_r};
			plcr_pkg::ADDR_SOC:      rd_data = soc_r;
			plcr_pkg::ADDR_GAUGE:    rd_data = {gauge_ok_r, 7'h00};
			default:                 rd_data = plcr_pkg::READ_UNMAPPED;
		endcase
	end

endmodule : plcr_regs

// ### logic/plcr_sync.sv
// plcr_sync: three-stage pin synchroniser with agreement filter
module plcr_sync #(
	parameter int        WIDTH = 2,
	parameter logic [1:0] INIT = 2'h3
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// a bit only moves once the last two stages agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r    <= INIT[WIDTH-1:0];
			s2_r    <= INIT[WIDTH-1:0];
			s3_r    <= INIT[WIDTH-1:0];
			level_o <= INIT[WIDTH-1:0];
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					level_o[i] <= s3_r[i];
				end
			end
		end
	end

endmodule : plcr_sync

// ### tb/plcr_partner.sv
// plcr_partner: behavioural power-line master feeding the slice's link inputs
module plcr_partner (
	input	wire logic	clk_i,
	output	logic		poll_o,
	output	logic		req_stb_o,
	output	logic [6:0]	req_code_o,
	output	logic		rx_done_o,
	output	logic [6:0]	rx_count_o,
	output	logic		soc_stb_o,
	output	logic [7:0]	soc_o,
	output	logic		gauge_ok_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{poll_o, req_stb_o, rx_done_o, soc_stb_o, gauge_ok_o} = 5'h00;
		{req_code_o, rx_count_o, soc_o} = 22'h2A5A5A;
	end
	// ************************************************************
	// packets: one-cycle strobes
	// ************************************************************
	// data flips after each strobe so stale values show
	task automatic poll(input int gap);
		repeat (gap + 1) @(posedge clk_i);
		poll_o <= 1'h1;
		@(posedge clk_i);
		poll_o <= 1'h0;
		#1;
	endtask : poll
	task automatic req(input logic [6:0] c);
		@(posedge clk_i);
		{req_stb_o, req_code_o} <= {1'h1, c};
		@(posedge clk_i);
		{req_stb_o, req_code_o} <= {1'h0, ~c};
		#1;
	endtask : req
	task automatic rx(input logic [6:0] n);
		@(posedge clk_i);
		{rx_done_o, rx_count_o} <= {1'h1, n};
		@(posedge clk_i);
		{rx_done_o, rx_count_o} <= {1'h0, ~n};
		#1;
	endtask : rx
	task automatic soc(input logic [7:0] v, input logic ok);
		@(posedge clk_i);
		{soc_stb_o, soc_o, gauge_ok_o} <= {1'h1, v, ok};
		@(posedge clk_i);
		{soc_stb_o, soc_o, gauge_ok_o} <= {1'h0, ~v, ~ok};
		#1;
	endtask : soc
endmodule : plcr_partner

// ### tb/plcr_regs_checker.sv
// plcr_regs_checker: port assertions for the command issue slice
module plcr_regs_checker (
	input	logic		CLOCK_I,
	input	logic		ARST_N_I,
	input	logic		LINK_POLL_I,
	input	logic		LINK_TX_STB_O,
	input	logic [6:0]	LINK_TX_CODE_O,
	input	logic [7:0]	LINK_TX_ARG_O,
	input	plcr_pkg::plcr_kind_e	LINK_TX_KIND_O,
	input	logic [3:0]	LINK_GPIO_RES_EN_O,
	input	logic [3:0]	LINK_GPIO_LEVEL_O,
	input	logic [8:0]	LINK_DOUT_LEN_O,
	input	logic [1:0]	LINK_UART_CHAN_O,
	input	logic		LINK_UART_RX_SW_O,
	input	logic		LINK_UART_TX_SW_O,
	input	logic		CMD_PENDING_O,
	input	logic		LINK_REQ_STB_I,
	input	logic [6:0]	LINK_REQ_CODE_I,
	input	logic		RX_BUFFER_FULL_I,
	input	logic		UART_REFUSE_I,
	input	logic		LINK_REQ_ACK_O,
	input	logic		LINK_REQ_NACK_O,
	input	logic		LINK_RX_DONE_I,
	input	logic		RX_NEW_DATA_O
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!ARST_N_I);

	property p_send; CMD_PENDING_O && LINK_POLL_I |=> LINK_TX_STB_O && !CMD_PENDING_O; endproperty
	a_send: assert property (p_send) else $error("no send on poll");
	property p_hold; CMD_PENDING_O && !LINK_POLL_I |=> CMD_PENDING_O; endproperty
	a_hold: assert property (p_hold) else $error("pending lost early");
	property p_once; LINK_TX_STB_O |=> !LINK_TX_STB_O [*2]; endproperty
	a_once: assert property (p_once) else $error("command sent twice");
	property p_kind; LINK_TX_STB_O |-> ((LINK_TX_KIND_O == plcr_pkg::KIND_UART)
		== (LINK_TX_CODE_O == 7'h06)) && ((LINK_TX_KIND_O == plcr_pkg::KIND_DOUT)
		== (LINK_TX_CODE_O == 7'h05)); endproperty
	a_kind: assert property (p_kind) else $error("code decode wrong");
	property p_gpio; LINK_TX_STB_O && LINK_TX_KIND_O == plcr_pkg::KIND_GPIO
		|-> {LINK_GPIO_RES_EN_O, LINK_GPIO_LEVEL_O} == LINK_TX_ARG_O; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio fields wrong");
	property p_dout; LINK_TX_STB_O && LINK_TX_KIND_O == plcr_pkg::KIND_DOUT
		|-> LINK_DOUT_LEN_O == {1'h0, LINK_TX_ARG_O} + 9'h001; endproperty
	a_dout: assert property (p_dout) else $error("length wrong");
	property p_ch2; LINK_TX_STB_O && LINK_TX_KIND_O == plcr_pkg::KIND_UART
		&& LINK_TX_ARG_O inside {8'h08, 8'h0C} |-> LINK_UART_CHAN_O == 2'h2
		&& LINK_UART_RX_SW_O && LINK_UART_TX_SW_O; endproperty
	a_ch2: assert property (p_ch2) else $error("loopback decode wrong");
	property p_ndout; LINK_REQ_STB_I && LINK_REQ_CODE_I == 7'h05 |=> LINK_REQ_NACK_O
		== $past(RX_BUFFER_FULL_I) && LINK_REQ_ACK_O != LINK_REQ_NACK_O; endproperty
	a_ndout: assert property (p_ndout) else $error("data-out answer wrong");
	property p_nuart; LINK_REQ_STB_I && LINK_REQ_CODE_I == 7'h06 |=> LINK_REQ_NACK_O
		== $past(UART_REFUSE_I) && LINK_REQ_ACK_O != LINK_REQ_NACK_O; endproperty
	a_nuart: assert property (p_nuart) else $error("uart answer wrong");
	property p_rx; LINK_RX_DONE_I |=> RX_NEW_DATA_O ##1 !RX_NEW_DATA_O; endproperty
	a_rx: assert property (p_rx) else $error("new-data pulse wrong");
endmodule : plcr_regs_checker

bind plcr_regs plcr_regs_checker u_plcr_regs_checker (.*);

// ### tb/testbench.sv
// testbench: two-wire register scenarios for the command issue slice
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// signals and instances
	// ************************************************************
	localparam logic [14:0] CMDS [17] = '{15'h0001, 15'h0003, 15'h0004, 15'h0005, 15'h0002,
		15'h03A5, 15'h0500, 15'h05FF, 15'h0600, 15'h0601, 15'h0602, 15'h0603, 15'h0604,
		15'h0607, 15'h0608, 15'h060C, 15'h7F42};
	localparam logic [6:0] RC [5] = '{7'h00, 7'h03, 7'h05, 7'h06, 7'h7F};
	logic			clk, arst_n, scl, sda_m, full, refuse, sda_o, sda_oe, poll, stb;
	logic			pend, rstb, ack, nack, rdone, newd, sstb, gok, rxs, txs;
	logic [6:0]		code, rcode, rcnt;
	logic [7:0]		arg, soc;
	logic [3:0]		res, lvl;
	logic [8:0]		len;
	logic [1:0]		chan;
	plcr_pkg::plcr_kind_e	kind;
	plcr_pkg::plcr_sys_e	sysr;
	int			fails, n_tests;
	wire			sda = sda_m & ~(sda_oe & ~sda_o);

	plcr_regs u_plcr_regs (.CLOCK_I(clk), .ARST_N_I(arst_n), .I2C_SCL_I(scl), .I2C_SDA_I(sda),
		.I2C_SDA_O(sda_o), .I2C_SDA_OE_O(sda_oe), .LINK_POLL_I(poll), .LINK_TX_STB_O(stb),
		.LINK_TX_CODE_O(code), .LINK_TX_ARG_O(arg), .LINK_TX_KIND_O(kind),
		.LINK_GPIO_RES_EN_O(res), .LINK_GPIO_LEVEL_O(lvl), .LINK_DOUT_LEN_O(len),
		.LINK_UART_CHAN_O(chan), .LINK_UART_RX_SW_O(rxs), .LINK_UART_TX_SW_O(txs),
		.LINK_SYS_REQ_O(sysr), .CMD_PENDING_O(pend), .LINK_REQ_STB_I(rstb),
		.LINK_REQ_CODE_I(rcode), .RX_BUFFER_FULL_I(full), .UART_REFUSE_I(refuse),
		.LINK_REQ_ACK_O(ack), .LINK_REQ_NACK_O(nack), .LINK_RX_DONE_I(rdone),
		.LINK_RX_COUNT_I(rcnt), .RX_NEW_DATA_O(newd), .LINK_SOC_STB_I(sstb),
		.LINK_SOC_I(soc), .LINK_GAUGE_OK_I(gok));
	plcr_partner u_plcr_partner (.clk_i(clk), .poll_o(poll), .req_stb_o(rstb),
		.req_code_o(rcode), .rx_done_o(rdone), .rx_count_o(rcnt), .soc_stb_o(sstb),
		.soc_o(soc), .gauge_ok_o(gok));

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	// ten cycles a phase outlasts the synchroniser lag
	task automatic hp;
		repeat (10) @(posedge clk);
	endtask : hp
	task automatic i2c_start;
		sda_m <= 1'h1;
		hp;
		scl <= 1'h1;
		hp;
		sda_m <= 1'h0;
		hp;
		scl <= 1'h0;
	endtask : i2c_start
	task automatic i2c_stop;
		sda_m <= 1'h0;
		hp;
		scl <= 1'h1;
		hp;
		sda_m <= 1'h1;
		hp;
	endtask : i2c_stop
	// ninth bit released: reads end with a nack
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_m <= (i == 0) ? 1'h1 : d[(i + 7) % 8];
			hp;
			scl <= 1'h1;
			hp;
			if (i > 0) q[i - 1] = sda;
			ack = ~sda;
			scl <= 1'h0;
		end
	endtask : xbyte
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
		logic [7:0] q;
		logic       k;
		i2c_start;
		xbyte({plcr_pkg::BUS_ADDR, 1'h0}, q, k);
		chk(k, 1'h1);
		xbyte(a, q, k);
		for (int j = n - 1; j >= 0; j--) xbyte(d[8*j+:8], q, k);
		i2c_stop;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic       k;
		i2c_start;
		xbyte({plcr_pkg::BUS_ADDR, 1'h0}, q, k);
		xbyte(a, q, k);
		i2c_start;
		xbyte({plcr_pkg::BUS_ADDR, 1'h1}, q, k);
		xbyte(8'hFF, q, k);
		i2c_stop;
		chk(q, e);
	endtask : rdc
	task automatic send(input logic [6:0] c, input logic [7:0] a, input int gap);
		plcr_pkg::plcr_kind_e k;
		plcr_pkg::plcr_sys_e  s;
		logic [3:0]           u;
		k = (c == 7'h00) ? plcr_pkg::KIND_SYS : (c == 7'h03) ? plcr_pkg::KIND_GPIO :
			(c == 7'h05) ? plcr_pkg::KIND_DOUT : (c == 7'h06) ? plcr_pkg::KIND_UART :
			plcr_pkg::KIND_NONE;
		// uart packed as {channel, rx, tx}
		u = (a == 8'h01) ? 4'h6 : (a == 8'h02) ? 4'h5 : (a == 8'h03) ? 4'h7 :
			(a == 8'h04) ? 4'hA : (a == 8'h07) ? 4'h9 : (a == 8'h08 || a == 8'h0C) ? 4'hB : 4'h0;
		s = (a == 8'h01) ? plcr_pkg::SYS_SOFT : (a == 8'h03) ? plcr_pkg::SYS_GAUGE :
			(a == 8'h04) ? plcr_pkg::SYS_FIFO : (a == 8'h05) ? plcr_pkg::SYS_FREE :
			plcr_pkg::SYS_NONE;
		wr(8'h37, {a, 1'h1, c}, 2);
		rdc(8'h38, {1'h1, c});
		u_plcr_partner.poll(gap);
		chk(stb, 1'h1);
		chk(pend, 1'h0);
		chk({code, arg}, {c, a});
		chk(kind, k);
		chk({res, lvl}, (k == plcr_pkg::KIND_GPIO) ? a : 8'h00);
		chk(len, (k == plcr_pkg::KIND_DOUT) ? {1'h0, a} + 9'h001 : 9'h000);
		if (k == plcr_pkg::KIND_UART) chk({chan, rxs, txs}, u);
		if (k == plcr_pkg::KIND_SYS) chk(sysr, s);
	endtask : send
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		logic [7:0] q;
		logic       k;
		{arst_n, full, refuse} = 3'h0;
		{scl, sda_m} = 2'h3;
		{fails, n_tests} = 64'h0;
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		repeat (12) @(posedge clk);
		for (int i = 0; i < 5; i++) rdc(8'h37 + 8'(i), 8'h00);
		chk(pend, 1'h0);
		i2c_start;
		xbyte({7'h2B, 1'h0}, q, k);
		chk(k, 1'h0);
		i2c_stop;
		wr(8'h50, 16'h005A, 1);
		rdc(8'h50, 8'h00);
		for (int i = 0; i < 17; i++) send(CMDS[i][14:8], CMDS[i][7:0], i % 4 * 6);
		wr(8'h37, 16'h5A83, 2);
		wr(8'h37, 16'h3385, 2);
		u_plcr_partner.poll(2);
		chk({stb, pend, code, arg}, {2'h2, 7'h03, 8'h5A});
		u_plcr_partner.poll(0);
		chk(stb, 1'h0);
		rdc(8'h38, 8'h05);
		rdc(8'h37, 8'h33);
		for (int c = 0; c < 20; c++) begin
			@(posedge clk);
			{full, refuse} <= 2'(c);
			u_plcr_partner.req(RC[c / 4]);
			k = (RC[c / 4] == 7'h05 && c[1]) || (RC[c / 4] == 7'h06 && c[0]);
			chk({nack, ack}, {k, ~k});
		end
		u_plcr_partner.rx(7'h7F);
		chk(newd, 1'h1);
		wr(8'h39, 16'h00FF, 1);
		rdc(8'h39, 8'h7F);
		u_plcr_partner.rx(7'h00);
		rdc(8'h39, 8'h00);
		u_plcr_partner.soc(8'hC8, 1'h1);
		rdc(8'h3A, 8'hC8);
		rdc(8'h3B, 8'h80);
		u_plcr_partner.soc(8'h37, 1'h0);
		rdc(8'h3A, 8'h37);
		rdc(8'h3B, 8'h00);
		test_done;
	end
	initial begin
		repeat (80000) @(posedge clk);
		fails++;
		test_done;
	end
endmodule : testbench
